/* File: rtl/tmcsq_pkg.sv */
`default_nettype none
package tmcsq_pkg;
   // ***************************************************************
   // Register word addresses (one index per 32-bit register)
   // ***************************************************************
   localparam logic [3:0] ADDR_CONTROL   = 4'h0; // control_word
   localparam logic [3:0] ADDR_STATUS    = 4'h1; // status_word
   localparam logic [3:0] ADDR_SHADOW    = 4'h2; // count_shadow (read only)
   localparam logic [3:0] ADDR_RELOAD1   = 4'h3; // first_reload_value
   localparam logic [3:0] ADDR_RELOAD2   = 4'h4; // second_reload_value
   localparam logic [3:0] ADDR_MATCH     = 4'h5; // match_register_and_flag value
   localparam logic [3:0] ADDR_PRESCALE  = 4'h6; // prescaler state (read only)

   // ***************************************************************
   // Control word fields
   // ***************************************************************
   localparam int CW_RUN      = 0;   // soft_run_enable
   localparam int CW_CPE      = 1;   // counter_prescaler_enable
   localparam int CW_GATE_EN  = 2;   // gate_enable
   localparam int CW_MODE_LO  = 3;   // three-bit mode
   localparam int CW_OC_LO    = 6;   // two-bit output_control_field
   localparam int CW_EXT_CLK  = 8;   // pick external_count_clock
   localparam int CW_PRE_EN   = 9;   // counter clocked from prescaler
   localparam int CW_IE_LO    = 10;  // three-bit interrupt_mask_bits
   localparam int CW_WIDTH    = 13;

   // ***************************************************************
   // Status word fields
   // ***************************************************************
   localparam int SW_TIMEOUT  = 0;   // timeout_flag
   localparam int SW_GATE_EV  = 1;   // gate_event_flag
   localparam int SW_EQUAL    = 2;   // equal_event_flag
   localparam int SW_MATCH    = 3;   // compare match flag
   localparam int SW_GATE_LVL = 4;   // gate_level_flag
   localparam int SW_PIN      = 5;   // pin level flag
   localparam int SW_RUNNING  = 6;   // running flag

   // ***************************************************************
   // Modes, output controls, reset values
   // ***************************************************************
   localparam logic [2:0] MODE_CAPTURE = 3'h0;
   localparam logic [2:0] MODE_SQUARE  = 3'h1;
   localparam logic [2:0] MODE_VARDUTY = 3'h2;
   localparam logic [1:0] OC_OFF    = 2'h0;
   localparam logic [1:0] OC_TOGGLE = 2'h1;
   localparam logic [1:0] OC_LOW    = 2'h2;
   localparam logic [1:0] OC_HIGH   = 2'h3;
   localparam logic [7:0]  PRESCALE_RESET = 8'hff;
   localparam logic [15:0] COUNT_RESET    = 16'h0000;
   localparam logic [15:0] COUNT_ZERO     = 16'h0000;
endpackage
`default_nettype wire

/* File: rtl/tmcsq_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module tmcsq_timer (
   input  wire logic        clk,
   input  wire logic        rst,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   // Pins
   input  wire logic        external_count_clock,
   input  wire logic        gate_input_n,
   output var  logic        timer_output_pin,
   output var  logic        irq_q
);

   // ***************************************************************
   // Registers and synchronisers
   // ***************************************************************
   logic [tmcsq_pkg::CW_WIDTH-1:0] control_word_q;   // Control word
   logic [15:0] first_reload_value_q;                // Reload one
   logic [15:0] second_reload_value_q;               // Reload two
   logic [15:0] match_value_q;                       // Compare value
   logic [15:0] count_q;                             // Live counter
   logic [15:0] count_shadow_q;                      // Readable copy
   logic [7:0]  prescale_q;                          // Prescaler
   logic        timeout_flag_q;                      // Sticky flags and match flag
   logic        gate_event_flag_q;
   logic        equal_event_flag_q;
   logic        match_flag_q;
   logic        running_q;                           // Running flag
   logic        loaded_q;                            // First load done
   logic        use_second_q;                        // Next load from two
   logic        pending_reload_q;                    // Timeout seen
   logic        half_q;                              // Half clock divider
   logic [1:0]  ext_sync_q;                          // External clock sync
   logic [1:0]  gate_sync_q;                         // Gate sync
   logic        ext_prev_q;                          // Edge detect
   logic        gate_prev_q;
   logic        pre_tick_q;                          // Prescaler falling out
   logic        shadow_go_q;                         // Shadow update strobe

   // Control decode
   logic [2:0] mode;
   logic [1:0] oc;
   logic [2:0] ie;
   logic       enabled;
   logic       gate_asserted;
   logic       cap_mode;
   logic       sq_mode;
   assign mode = control_word_q[tmcsq_pkg::CW_MODE_LO +: 3];
   assign oc   = control_word_q[tmcsq_pkg::CW_OC_LO +: 2];
   assign ie   = control_word_q[tmcsq_pkg::CW_IE_LO +: 3];
   assign enabled = control_word_q[tmcsq_pkg::CW_RUN] & control_word_q[tmcsq_pkg::CW_CPE];
   assign gate_asserted = ~gate_sync_q[1];
   assign cap_mode = (mode == tmcsq_pkg::MODE_CAPTURE);
   assign sq_mode  = (mode == tmcsq_pkg::MODE_SQUARE) |
                     (mode == tmcsq_pkg::MODE_VARDUTY);

   // Square modes run only with gate asserted when gate enable is set
   logic go;
   assign go = enabled & (cap_mode |
               (sq_mode & (~control_word_q[tmcsq_pkg::CW_GATE_EN] | gate_asserted)));

   // Output event decode, shared for match and timeout
   function automatic logic pin_next(input logic [1:0] ctl, input logic cur);
      case (ctl)
         tmcsq_pkg::OC_TOGGLE: pin_next = ~cur;
         tmcsq_pkg::OC_LOW:    pin_next = 1'b0;
         tmcsq_pkg::OC_HIGH:   pin_next = 1'b1;
         default:              pin_next = 1'b0;
      endcase
   endfunction

   // ***************************************************************
   // Input synchronisers
   // ***************************************************************
   // Two flops on each pin before any logic looks at it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_sync_q  <= 2'h0;
         gate_sync_q <= 2'h3;
      end else begin
         ext_sync_q  <= {ext_sync_q[0], external_count_clock};
         gate_sync_q <= {gate_sync_q[0], gate_input_n};
      end
   end

   // Edge history of synced levels
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_prev_q  <= 1'b0;
         gate_prev_q <= 1'b1;
      end else begin
         ext_prev_q  <= ext_sync_q[1];
         gate_prev_q <= gate_sync_q[1];
      end
   end

   // ***************************************************************
   // Clock selection
   // ***************************************************************
   // Half system clock; its falling phase is the selected tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         half_q <= 1'b0;
      end else begin
         half_q <= ~half_q;
      end
   end

   logic sel_tick;     // Falling edge of selected clock
   logic cnt_tick;     // Falling edge of counter clock
   assign sel_tick = control_word_q[tmcsq_pkg::CW_EXT_CLK] ?
                     (ext_prev_q & ~ext_sync_q[1]) : half_q;
   assign cnt_tick = control_word_q[tmcsq_pkg::CW_PRE_EN] ? pre_tick_q : sel_tick;

   // Prescaler: stalls with the counter; wrap marks a counter tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prescale_q <= tmcsq_pkg::PRESCALE_RESET;
         pre_tick_q <= 1'b0;
      end else begin
         pre_tick_q <= 1'b0;
         if (!go) begin
            if (!enabled) prescale_q <= tmcsq_pkg::PRESCALE_RESET;
         end else if (sel_tick) begin
            prescale_q <= prescale_q - 8'h01;
            pre_tick_q <= (prescale_q == 8'h00);
         end
      end
   end

   // ***************************************************************
   // Counter
   // ***************************************************************
   // Load on first tick after start, then count; reload after timeout.
   // Reload values are sampled on the tick itself, so a racing write
   // can land one period late.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q          <= tmcsq_pkg::COUNT_RESET;
         loaded_q         <= 1'b0;
         use_second_q     <= 1'b0;
         pending_reload_q <= 1'b0;
      end else if (!enabled) begin
         loaded_q         <= 1'b0;
         use_second_q     <= 1'b0;
         pending_reload_q <= 1'b0;
      end else if (go && cnt_tick) begin
         if (!loaded_q || pending_reload_q) begin
            loaded_q         <= 1'b1;
            pending_reload_q <= 1'b0;
            if (use_second_q && mode == tmcsq_pkg::MODE_VARDUTY) begin
               count_q <= second_reload_value_q;
            end else begin
               count_q <= first_reload_value_q;
            end
            // Duty mode alternates loads after each timeout
            if (loaded_q && mode == tmcsq_pkg::MODE_VARDUTY) begin
               use_second_q <= ~use_second_q;
            end else if (!loaded_q) begin
               use_second_q <= 1'b1;
            end
         end else begin
            count_q <= count_q - 16'h0001;
            if (count_q == 16'h0001) pending_reload_q <= 1'b1;
         end
      end
   end

   // Strobe one cycle after a counter tick to refresh the shadow
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shadow_go_q <= 1'b0;
      end else begin
         shadow_go_q <= go & cnt_tick;
      end
   end

   // Shadow copy frozen while gate event is set in capture mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_shadow_q <= tmcsq_pkg::COUNT_RESET;
      end else if (shadow_go_q && !(cap_mode && gate_event_flag_q)) begin
         count_shadow_q <= count_q;
      end
   end

   // ***************************************************************
   // Events, flags and output pin
   // ***************************************************************
   logic eq_ev;      // Counter just reached compare
   logic to_ev;      // Counter just reached zero
   logic gate_ev;    // Gate event this cycle
   logic stat_wr;    // Status write strobe
   assign eq_ev = shadow_go_q & loaded_q & (count_q == match_value_q);
   assign to_ev = shadow_go_q & loaded_q & (count_q == tmcsq_pkg::COUNT_ZERO);
   assign gate_ev = enabled & control_word_q[tmcsq_pkg::CW_GATE_EN] &
                    (cap_mode ? (~gate_prev_q & gate_sync_q[1])
                              : (sq_mode & ~gate_prev_q & gate_sync_q[1]));
   // Clear only at the completing edge, so an event that lands in the wait cycle is cleared as well
   assign stat_wr = avs_write & ~avs_waitrequest & (avs_address == tmcsq_pkg::ADDR_STATUS);

   // Sticky flags: set wins over write-one clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timeout_flag_q     <= 1'b0;
         gate_event_flag_q  <= 1'b0;
         equal_event_flag_q <= 1'b0;
      end else begin
         if (to_ev) timeout_flag_q <= 1'b1;
         else if (stat_wr && avs_writedata[tmcsq_pkg::SW_TIMEOUT]) timeout_flag_q <= 1'b0;
         if (gate_ev) gate_event_flag_q <= 1'b1;
         else if (stat_wr && avs_writedata[tmcsq_pkg::SW_GATE_EV]) gate_event_flag_q <= 1'b0;
         if (eq_ev) equal_event_flag_q <= 1'b1;
         else if (stat_wr && avs_writedata[tmcsq_pkg::SW_EQUAL]) equal_event_flag_q <= 1'b0;
      end
   end

   // Match flag set on compare, cleared on timeout or stop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         match_flag_q <= 1'b0;
      end else if (eq_ev) begin
         match_flag_q <= 1'b1;
      end else if (to_ev || !enabled) begin
         match_flag_q <= 1'b0;
      end
   end

   // Running flag follows start and gate pause
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         running_q <= 1'b0;
      end else begin
         running_q <= go;
      end
   end

   // Output pin; compare events only move it in capture mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timer_output_pin <= 1'b0;
      end else if (!enabled || oc == tmcsq_pkg::OC_OFF) begin
         timer_output_pin <= 1'b0;
      end else if (to_ev || (eq_ev && cap_mode)) begin
         timer_output_pin <= pin_next(oc, timer_output_pin);
      end
   end

   // Interrupt request from masked sticky flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(ie & {equal_event_flag_q, gate_event_flag_q, timeout_flag_q});
      end
   end

   // ***************************************************************
   // Avalon-MM slave
   // ***************************************************************
   // Waitrequest high on idle, dropped one cycle after a request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      end
   end

   logic acc;   // Access completes this edge
   assign acc = ~avs_waitrequest;

   // Writable registers; control only sane while stopped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         control_word_q        <= '0;
         first_reload_value_q  <= 16'h0000;
         second_reload_value_q <= 16'h0000;
         match_value_q         <= 16'h0000;
      end else if (avs_write && acc) begin
         case (avs_address)
            tmcsq_pkg::ADDR_CONTROL: control_word_q <= avs_writedata[tmcsq_pkg::CW_WIDTH-1:0];
            tmcsq_pkg::ADDR_RELOAD1: first_reload_value_q  <= avs_writedata[15:0];
            tmcsq_pkg::ADDR_RELOAD2: second_reload_value_q <= avs_writedata[15:0];
            tmcsq_pkg::ADDR_MATCH:   match_value_q <= avs_writedata[15:0];
            default: ;
         endcase
      end
   end

   // Read mux registered in the wait cycle; unmapped reads zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else begin
         case (avs_address)
            tmcsq_pkg::ADDR_CONTROL: avs_readdata <= {19'h0, control_word_q};
            tmcsq_pkg::ADDR_STATUS:  avs_readdata <= {25'h0, running_q, timer_output_pin,
               gate_sync_q[1], match_flag_q, equal_event_flag_q,
               gate_event_flag_q, timeout_flag_q};
            tmcsq_pkg::ADDR_SHADOW:  avs_readdata <= {16'h0, count_shadow_q};
            tmcsq_pkg::ADDR_RELOAD1: avs_readdata <= {16'h0, first_reload_value_q};
            tmcsq_pkg::ADDR_RELOAD2: avs_readdata <= {16'h0, second_reload_value_q};
            tmcsq_pkg::ADDR_MATCH:   avs_readdata <= {16'h0, match_value_q};
            tmcsq_pkg::ADDR_PRESCALE: avs_readdata <= {24'h0, prescale_q};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: tb/tmcsq_timer_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ********
// Port checks of the timer channel
// ********
module tmcsq_timer_asserts (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        external_count_clock,
   input wire logic        gate_input_n,
   input wire logic        timer_output_pin,
   input wire logic        irq_q
);
   logic [12:0] ctrl_q; // Last control word written
   logic        rd_ok;  // Read completing this edge

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   assign rd_ok = avs_read && !avs_waitrequest;

   // Control copy, so pin and irq checks know the settings
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 13'h0;
      end else if (avs_write && !avs_waitrequest && avs_address == 4'h0) begin
         ctrl_q <= avs_writedata[12:0];
      end
   end

   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered in the next cycle");
   a_reset_quiet: assert property ($fell(rst) |-> !timer_output_pin && !irq_q && avs_waitrequest)
      else $error("outputs not quiet after reset");
   a_unmapped_zero: assert property (rd_ok && avs_address > 4'h6 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_presc_width:
      assert property (rd_ok && avs_address == 4'h6 |-> avs_readdata[31:8] == 24'h0)
      else $error("prescaler read wider than eight bits");
   a_ctrl_readback:
      assert property (rd_ok && avs_address == 4'h0 |-> avs_readdata == {19'h0, ctrl_q})
      else $error("control readback differs");
   a_irq_masked:
      assert property (ctrl_q[12:10] == 3'h0 && $past(ctrl_q[12:10]) == 3'h0 |-> !irq_q)
      else $error("irq raised while all masked");
   a_pin_parked:
      assert property ((!ctrl_q[0] || ctrl_q[7:6] == 2'h0) && $past(ctrl_q) == ctrl_q
                       |-> !timer_output_pin)
      else $error("pin driven while stopped or off");

   c_pin_rise: cover property ($rose(timer_output_pin));
   c_irq_rise: cover property ($rose(irq_q));
   c_stat_read: cover property (rd_ok && avs_address == 4'h1);
endmodule

bind tmcsq_timer tmcsq_timer_asserts u_chk (
   .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .external_count_clock(external_count_clock),
   .gate_input_n(gate_input_n), .timer_output_pin(timer_output_pin), .irq_q(irq_q)
);
`default_nettype wire

/* File: tb/tmcsq_host.sv */
`timescale 1ns/100ps
`default_nettype none
// ********
// Processor side: Avalon master with one-shot transfers
// ********
module tmcsq_host (
   input  wire logic        clk,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest,
   input  wire logic        irq_q,
   output var  logic [3:0]  avs_address,
   output var  logic        avs_read,
   output var  logic        avs_write,
   output var  logic [31:0] avs_writedata,
   output var  logic        rd_done,
   output var  logic [32:0] rd_val
);
   // Idle bus from time zero
   initial begin
      {avs_address, avs_read, avs_write, avs_writedata, rd_done, rd_val} = '0;
   end

   // One access; held until waitrequest is sampled low, no cycle count assumed
   task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_read      <= rd;
      avs_write     <= !rd;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      if (rd) begin
         rd_val  <= {irq_q, avs_readdata}; // Irq line seen with the data
         rd_done <= 1'b1;
      end
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
      rd_done <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   // ********
   // Wiring and bench state
   // ********
   localparam logic [32:0] S_TO  = 33'h1 << tmcsq_pkg::SW_TIMEOUT;
   localparam logic [32:0] S_GEV = 33'h1 << tmcsq_pkg::SW_GATE_EV;
   localparam logic [32:0] S_EQ  = 33'h1 << tmcsq_pkg::SW_EQUAL;
   localparam logic [32:0] S_LVL = 33'h1 << tmcsq_pkg::SW_GATE_LVL;
   localparam logic [32:0] S_PIN = 33'h1 << tmcsq_pkg::SW_PIN;
   localparam logic [32:0] S_RUN = 33'h1 << tmcsq_pkg::SW_RUNNING;
   localparam logic [32:0] S_IRQ = 33'h1_0000_0000; // Irq above data
   localparam logic [32:0] ALL   = 33'h0_ffff_ffff;
   typedef struct {logic k; logic [32:0] v; logic [32:0] m;} tmcsq_note_t; // k: period
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr;
   logic        rd, wr, wait_r, pin, irq, rd_done;
   logic [31:0] wdata, rdata, r;
   logic [32:0] rd_val;
   logic        ext_clk = 1'b0;
   logic        gate_n = 1'b0; // Gate asserted
   logic        last_pin = 1'b0;
   int          since = 0;
   int          ext_div = 0;
   int          errors = 0;
   int          num_checks = 0;
   tmcsq_note_t notes[$];

   tmcsq_timer dut (
      .clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_r),
      .external_count_clock(ext_clk), .gate_input_n(gate_n),
      .timer_output_pin(pin), .irq_q(irq)
   );
   tmcsq_host host (
      .clk(clk), .avs_readdata(rdata), .avs_waitrequest(wait_r), .irq_q(irq),
      .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
      .rd_done(rd_done), .rd_val(rd_val)
   );

   always #5 clk = ~clk;

   // External count clock, ten system clocks per period
   always @(posedge clk) begin
      ext_div <= (ext_div == 4) ? 0 : ext_div + 1;
      if (ext_div == 4) begin
         ext_clk <= ~ext_clk;
      end
   end

   // Watcher: oldest note against each read or pin edge
   always @(posedge clk) begin
      last_pin <= pin;
      since    <= since + 1;
      if (rd_done === 1'b1 && notes.size() > 0 && !notes[0].k) begin
         check("read", rd_val & notes[0].m, notes[0].v & notes[0].m);
         void'(notes.pop_front());
      end
      if (pin !== last_pin) begin
         since <= 1;
         if (notes.size() > 0 && notes[0].k) begin
            check("pin period", {1'b0, 32'(since)}, notes[0].v);
            void'(notes.pop_front());
         end
      end
   end

   // ********
   // Helpers
   // ********
   task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rdx(input logic [3:0] a, input logic [32:0] v, input logic [32:0] m);
      notes.push_back('{1'b0, v, m});
      host.xfer(1'b1, a, 32'h0);
   endtask
   task automatic st(input logic [32:0] v, input logic [32:0] m);
      rdx(tmcsq_pkg::ADDR_STATUS, v, m);
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      host.xfer(1'b0, a, d);
   endtask
   task automatic per(input int v);
      notes.push_back('{1'b1, 33'(v), ALL});
   endtask
   function automatic logic [31:0] cw(input logic [2:0] md, input logic [1:0] oc,
                                      input logic ge, input logic [2:0] ie, input logic ex);
      cw = 32'h0;
      cw[tmcsq_pkg::CW_RUN] = 1'b1;
      cw[tmcsq_pkg::CW_CPE] = 1'b1;
      cw[tmcsq_pkg::CW_GATE_EN] = ge;
      cw[tmcsq_pkg::CW_MODE_LO +: 3] = md;
      cw[tmcsq_pkg::CW_OC_LO +: 2] = oc;
      cw[tmcsq_pkg::CW_EXT_CLK] = ex;
      cw[tmcsq_pkg::CW_IE_LO +: 3] = ie;
   endfunction
   // Bounded waits: first pin rise, then all notes consumed
   task automatic rise_and_drain(input int a, input int b, input int c);
      for (int i = 0; i < 300 && pin !== 1'b1; i++) @(negedge clk);
      @(negedge clk); // Watcher restarts its count on this rise first
      per(a);
      per(b);
      per(c);
      for (int i = 0; i < 400 && notes.size() > 0; i++) @(posedge clk);
      check("pending notes", 33'(notes.size()), 33'h0);
      notes.delete();
      wr_reg(tmcsq_pkg::ADDR_CONTROL, 32'h0);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ********
   // Scenarios
   // ********
   initial begin
      void'($urandom(32'hb248));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rdx(tmcsq_pkg::ADDR_SHADOW, 33'h0, ALL);
      rdx(tmcsq_pkg::ADDR_PRESCALE, 33'hff, ALL);
      rdx(4'hf, 33'h0, ALL);
      r = $urandom;
      wr_reg(tmcsq_pkg::ADDR_RELOAD2, {16'h0, r[15:0]});
      rdx(tmcsq_pkg::ADDR_RELOAD2, {17'h0, r[15:0]}, ALL);
      gate_n <= 1'b1;
      repeat (4) @(posedge clk);
      st(S_LVL, S_LVL);
      gate_n <= 1'b0;
      wr_reg(tmcsq_pkg::ADDR_RELOAD1, 32'h3);
      // Square wave, timeout irq, gate ignored: 2*(3+1) clocks per toggle
      wr_reg(tmcsq_pkg::ADDR_CONTROL, cw(tmcsq_pkg::MODE_SQUARE, tmcsq_pkg::OC_TOGGLE, 1'b0, 3'h1, 1'b0));
      repeat (10) @(posedge clk); // First timeout needs about nine clocks
      gate_n <= 1'b1;
      st(S_TO | S_RUN | S_IRQ, S_TO | S_RUN | S_IRQ | S_GEV | S_LVL);
      gate_n <= 1'b0;
      rise_and_drain(8, 8, 8);
      // Counter fed from the external clock: ten clocks per tick
      wr_reg(tmcsq_pkg::ADDR_CONTROL, cw(tmcsq_pkg::MODE_SQUARE, tmcsq_pkg::OC_TOGGLE, 1'b0, 3'h0, 1'b1));
      rise_and_drain(40, 40, 40);
      wr_reg(tmcsq_pkg::ADDR_RELOAD1, 32'h4);
      wr_reg(tmcsq_pkg::ADDR_RELOAD2, 32'h2);
      wr_reg(tmcsq_pkg::ADDR_CONTROL, cw(tmcsq_pkg::MODE_VARDUTY, tmcsq_pkg::OC_TOGGLE, 1'b0, 3'h0, 1'b0));
      rise_and_drain(6, 10, 6);
      // Capture square wave: toggle on compare at half reload and on timeout
      wr_reg(tmcsq_pkg::ADDR_MATCH, 32'h2);
      wr_reg(tmcsq_pkg::ADDR_CONTROL,
             cw(tmcsq_pkg::MODE_CAPTURE, tmcsq_pkg::OC_TOGGLE, 1'b0, 3'h0, 1'b0));
      rise_and_drain(4, 6, 4);
      // Fixed output control codes; toggle is covered above
      for (int oc = 0; oc < 4; oc++) begin
         if (oc != 1) begin
            wr_reg(tmcsq_pkg::ADDR_CONTROL, cw(tmcsq_pkg::MODE_SQUARE, 2'(oc), 1'b0, 3'h0, 1'b0));
            repeat (40) @(posedge clk);
            st((oc == 3) ? S_PIN : 33'h0, S_PIN);
            wr_reg(tmcsq_pkg::ADDR_CONTROL, 32'h0);
         end
      end
      // Gated square: start needs the gate, negation pauses and flags
      gate_n <= 1'b1;
      wr_reg(tmcsq_pkg::ADDR_CONTROL, cw(tmcsq_pkg::MODE_SQUARE, tmcsq_pkg::OC_TOGGLE, 1'b1, 3'h2, 1'b0));
      st(33'h0, S_RUN);
      gate_n <= 1'b0;
      repeat (6) @(posedge clk);
      st(S_RUN, S_RUN | S_GEV);
      gate_n <= 1'b1;
      repeat (6) @(posedge clk);
      st(S_GEV | S_IRQ, S_RUN | S_GEV | S_IRQ);
      wr_reg(tmcsq_pkg::ADDR_STATUS, 32'h0);
      st(S_GEV, S_GEV);
      wr_reg(tmcsq_pkg::ADDR_STATUS, S_GEV[31:0]);
      gate_n <= 1'b0;
      repeat (6) @(posedge clk);
      st(S_RUN, S_RUN | S_GEV | S_IRQ);
      wr_reg(tmcsq_pkg::ADDR_CONTROL, 32'h0);
      // Capture: compare forces pin high, gate edge captures, counting goes on
      wr_reg(tmcsq_pkg::ADDR_STATUS, 32'h7);
      wr_reg(tmcsq_pkg::ADDR_RELOAD1, 32'h40);
      wr_reg(tmcsq_pkg::ADDR_MATCH, 32'h20);
      wr_reg(tmcsq_pkg::ADDR_CONTROL, cw(tmcsq_pkg::MODE_CAPTURE, tmcsq_pkg::OC_HIGH, 1'b1, 3'h4, 1'b0));
      rdx(tmcsq_pkg::ADDR_CONTROL,
          {1'b0, cw(tmcsq_pkg::MODE_CAPTURE, tmcsq_pkg::OC_HIGH, 1'b1, 3'h4, 1'b0)}, ALL);
      repeat (100) @(posedge clk);
      st(S_EQ | S_PIN | S_RUN | S_IRQ, S_EQ | S_PIN | S_RUN | S_IRQ | S_GEV);
      gate_n <= 1'b1;
      wr_reg(tmcsq_pkg::ADDR_STATUS, S_TO[31:0]);
      repeat (200) @(posedge clk);
      st(S_GEV | S_TO | S_RUN, S_GEV | S_TO | S_RUN);
      report_and_stop();
   end

   // Watchdog: the run needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
